// [verilog/status_out_pkg.sv]
// Purpose: Shared constants and types for the configurable status outputs.
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register.
// Notes: Offsets are byte addresses; unused register bits read as zero.
package status_out_pkg;
	localparam logic [7:0] OFS_FUNC_SEL_1 = 8'h00;
	localparam logic [7:0] OFS_AUX_1 = 8'h04;
	localparam logic [7:0] OFS_FUNC_SEL_2 = 8'h08;
	localparam logic [7:0] OFS_AUX_2 = 8'h0C;
	localparam logic [7:0] OFS_MAX_SPEED = 8'h10;
	localparam logic [7:0] OFS_UNDERVOLT = 8'h14;
	localparam logic [7:0] OFS_CTRL = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;
	localparam int CTRL_SW_ENABLE = 0;
	localparam int CTRL_STYLE_LO = 1;
	localparam int CTRL_IO_EXP = 3;
	localparam int ST_LEVEL_LO = 0;
	localparam int ST_ENABLED = 2;
	localparam int ST_CHARGED = 3;
	localparam int ST_UNDERVOLT = 4;
	localparam int ST_NEXTINPOS = 5;
	localparam logic [5:0] RST_FUNC_SEL = 6'h00;
	localparam logic [31:0] RST_AUX = 32'h0000_0000;
	localparam logic [31:0] RST_MAX_SPEED = 32'h0000_0000;
	localparam logic [15:0] RST_UNDERVOLT = 16'h0000;
	localparam logic [31:0] BAND_DIVISOR = 32'h0000_0064;
	localparam logic [31:0] POS_INC_PER_TURN = 32'h0010_0000;

	typedef enum logic [1:0] {
		STYLE_TOGGLE_START = 2'b00,
		STYLE_PULSE = 2'b01,
		STYLE_TOGGLE_END = 2'b10
	} style_e;

	typedef enum logic [5:0] {
		FN_OFF = 6'b000000, FN_VEL_BELOW = 6'b000001, FN_VEL_ABOVE = 6'b000010,
		FN_CHARGING = 6'b000011, FN_REGEN = 6'b000100, FN_SW_LIMIT = 6'b000101,
		FN_POS_ABOVE = 6'b000110, FN_IN_POS = 6'b000111, FN_CUR_BELOW = 6'b001000,
		FN_CUR_ABOVE = 6'b001001, FN_FOLLOW_ERR = 6'b001010, FN_FOLDBACK = 6'b001011,
		FN_POSREG1 = 6'b001100, FN_POSREG2 = 6'b001101, FN_POSREG3 = 6'b001110,
		FN_POSREG4 = 6'b001111, FN_NEXT_INPOS = 6'b010000, FN_ERR_WARN = 6'b010001,
		FN_ERR = 6'b010010, FN_DC_ABOVE = 6'b010011, FN_DC_BELOW = 6'b010100,
		FN_ENABLED = 6'b010101, FN_ZERO_PULSE = 6'b010110, FN_EXP_CARD = 6'b010111,
		FN_HOMED = 6'b011000, FN_POSREG0 = 6'b011100, FN_POSREG5 = 6'b011101,
		FN_POSREG_ANY = 6'b011110, FN_AI1_BELOW = 6'b011111, FN_AI1_ABOVE = 6'b100000
	} func_e;
endpackage

// [verilog/pin_sync.sv]
// Purpose: Two-stage synchroniser for pin levels.
// Assumes: Inputs are asynchronous levels, not single short events.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // pin_sync

// [verilog/signed_mag.sv]
// Purpose: Magnitude of a signed 32-bit quantity.
// Assumes: Most negative input wraps naturally to 2^31 unsigned.
// Notes: Purely combinational.
`timescale 1ns/10ps
module signed_mag (
	// Value
	input wire logic signed [31:0] value,
	output logic [31:0] magnitude
);
	always_comb begin
		magnitude = value[31] ? 32'(-value) : 32'(value);
	end
endmodule // signed_mag

// [verilog/status_outputs.sv]
// Purpose: Two configurable logic status outputs of a servo drive with an AHB-Lite register file.
// Assumes: Measured quantities arrive from drive logic on hclk; pins are asynchronous.
// Notes: Zero-wait-state slave, response always OKAY, unmapped reads return zero.
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module status_outputs (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Pins
	input wire logic hw_enable_pin,
	input wire logic zero_mark_pin,
	// Measured quantities
	input wire logic signed [31:0] actual_velocity,
	input wire logic signed [31:0] rms_current_ma,
	input wire logic signed [31:0] shaft_position,
	input wire logic [15:0] dc_link_volts,
	input wire logic signed [15:0] analog_input_one_mv,
	// Drive state
	input wire logic link_charged,
	input wire logic regen_exceeded,
	input wire logic sw_limit_reached,
	input wire logic target_in_window,
	input wire logic sequence_active,
	input wire logic last_task,
	input wire logic following_error_exceeded,
	input wire logic foldback_reached,
	input wire logic [5:0] position_register,
	input wire logic error_present,
	input wire logic warning_present,
	input wire logic disabling_error,
	input wire logic reference_available,
	// Motion block events, one-cycle pulses
	input wire logic first_block_start,
	input wire logic block_start,
	input wire logic block_end,
	// Outputs
	output logic [1:0] logic_status_output,
	output logic drive_enabled
);
	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [1:0][5:0] func_sel;
		logic [1:0][31:0] aux;
		logic [31:0] max_speed;
		logic [15:0] undervolt;
		logic sw_enable;
		logic [1:0] style;
		logic io_exp;
		logic [31:0] band;
		logic charge_done;
		logic nextinpos;
		logic [1:0] level;
		logic [1:0] vel_low;
		logic [1:0] vel_high;
		logic enabled;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
	} state_s;

	state_s state_q;
	state_s state_d;
	logic [1:0] pins_sync;
	logic hw_enable;
	logic zero_mark;
	logic [31:0] vel_mag;
	logic [31:0] cur_mag;
	logic undervolt_now;
	logic enabled_now;
	logic [1:0] level_now;
	logic [1:0] vel_low_now;
	logic [1:0] vel_high_now;
	logic addr_phase;
	logic [31:0] read_word;

	pin_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in({zero_mark_pin, hw_enable_pin}),
		.sync_out(pins_sync)
	);

	assign hw_enable = pins_sync[0];
	assign zero_mark = pins_sync[1];

	signed_mag u_vel_mag (
		.value(actual_velocity),
		.magnitude(vel_mag)
	);

	signed_mag u_cur_mag (
		.value(rms_current_ma),
		.magnitude(cur_mag)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Drive-wide indications shared by both outputs.
	assign undervolt_now = dc_link_volts < state_q.undervolt;
	assign enabled_now = hw_enable && state_q.sw_enable && !disabling_error
		&& state_q.charge_done && !undervolt_now;

	////////////////////////////////////////////////////////////////////////////////
	// Per-output function selection; each output has its own code and aux threshold, while band, style and io_exp are shared.
	for (genvar i = 0; i < 2; i++) begin : g_out
		logic signed [33:0] thr;
		logic signed [33:0] thr_band;
		logic signed [33:0] vel_x;
		logic signed [33:0] cur_x;
		logic signed [33:0] pos_x;
		logic signed [33:0] dc_x;
		logic signed [33:0] ai_x;

		assign thr = {{2{state_q.aux[i][31]}}, state_q.aux[i]};
		assign thr_band = thr + {2'b00, state_q.band};
		assign vel_x = {2'b00, vel_mag};
		assign cur_x = {2'b00, cur_mag};
		assign pos_x = {{2{shaft_position[31]}}, shaft_position};
		assign dc_x = {18'h0_0000, dc_link_volts};
		assign ai_x = {{18{analog_input_one_mv[15]}}, analog_input_one_mv};

		// Hysteresis keeps the velocity-below output from chattering near the threshold; velocity-above switches at the threshold alone.
		always_comb begin
			if (vel_x < thr) begin
				vel_low_now[i] = 1'b1;
			end else if (vel_x > thr_band) begin
				vel_low_now[i] = 1'b0;
			end else begin
				vel_low_now[i] = state_q.vel_low[i];
			end
			if (vel_x > thr) begin
				vel_high_now[i] = 1'b1;
			end else if (vel_x < thr_band) begin
				vel_high_now[i] = 1'b0;
			end else begin
				vel_high_now[i] = state_q.vel_high[i];
			end
		end

		always_comb begin
			case (state_q.func_sel[i])
				status_out_pkg::FN_VEL_BELOW:
					level_now[i] = vel_low_now[i];
				status_out_pkg::FN_VEL_ABOVE:
					level_now[i] = vel_high_now[i];
				status_out_pkg::FN_CHARGING:
					level_now[i] = !state_q.charge_done || undervolt_now;
				status_out_pkg::FN_REGEN:
					level_now[i] = regen_exceeded;
				status_out_pkg::FN_SW_LIMIT:
					level_now[i] = sw_limit_reached;
				status_out_pkg::FN_POS_ABOVE:
					level_now[i] = pos_x > thr;
				status_out_pkg::FN_IN_POS:
					level_now[i] = target_in_window && (!sequence_active || last_task);
				status_out_pkg::FN_CUR_BELOW:
					level_now[i] = cur_x < thr;
				status_out_pkg::FN_CUR_ABOVE:
					level_now[i] = cur_x > thr;
				status_out_pkg::FN_FOLLOW_ERR:
					level_now[i] = !following_error_exceeded;
				status_out_pkg::FN_FOLDBACK:
					level_now[i] = foldback_reached;
				status_out_pkg::FN_POSREG1:
					level_now[i] = position_register[1];
				status_out_pkg::FN_POSREG2:
					level_now[i] = position_register[2];
				status_out_pkg::FN_POSREG3:
					level_now[i] = position_register[3];
				status_out_pkg::FN_POSREG4:
					level_now[i] = position_register[4];
				status_out_pkg::FN_NEXT_INPOS:
					level_now[i] = state_q.nextinpos;
				status_out_pkg::FN_ERR_WARN:
					level_now[i] = error_present || warning_present;
				status_out_pkg::FN_ERR:
					level_now[i] = error_present;
				status_out_pkg::FN_DC_ABOVE:
					level_now[i] = dc_x > thr;
				status_out_pkg::FN_DC_BELOW:
					level_now[i] = dc_x < thr;
				status_out_pkg::FN_ENABLED:
					level_now[i] = enabled_now;
				status_out_pkg::FN_ZERO_PULSE:
					level_now[i] = zero_mark;
				status_out_pkg::FN_HOMED:
					level_now[i] = reference_available;
				status_out_pkg::FN_POSREG0:
					level_now[i] = state_q.io_exp && position_register[0];
				status_out_pkg::FN_POSREG5:
					level_now[i] = state_q.io_exp && position_register[5];
				status_out_pkg::FN_POSREG_ANY:
					level_now[i] = |position_register;
				status_out_pkg::FN_AI1_BELOW:
					level_now[i] = ai_x < thr;
				status_out_pkg::FN_AI1_ABOVE:
					level_now[i] = ai_x > thr;
				default:
					level_now[i] = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register read view.
	assign addr_phase = hsel && htrans[1] && hready;

	always_comb begin
		read_word = 32'h0000_0000;
		if (haddr[7:0] == status_out_pkg::OFS_FUNC_SEL_1) begin
			read_word[5:0] = state_q.func_sel[0];
		end else if (haddr[7:0] == status_out_pkg::OFS_AUX_1) begin
			read_word = state_q.aux[0];
		end else if (haddr[7:0] == status_out_pkg::OFS_FUNC_SEL_2) begin
			read_word[5:0] = state_q.func_sel[1];
		end else if (haddr[7:0] == status_out_pkg::OFS_AUX_2) begin
			read_word = state_q.aux[1];
		end else if (haddr[7:0] == status_out_pkg::OFS_MAX_SPEED) begin
			read_word = state_q.max_speed;
		end else if (haddr[7:0] == status_out_pkg::OFS_UNDERVOLT) begin
			read_word[15:0] = state_q.undervolt;
		end else if (haddr[7:0] == status_out_pkg::OFS_CTRL) begin
			read_word[status_out_pkg::CTRL_SW_ENABLE] = state_q.sw_enable;
			read_word[status_out_pkg::CTRL_STYLE_LO +: 2] = state_q.style;
			read_word[status_out_pkg::CTRL_IO_EXP] = state_q.io_exp;
		end else if (haddr[7:0] == status_out_pkg::OFS_STATUS) begin
			read_word[status_out_pkg::ST_LEVEL_LO +: 2] = state_q.level;
			read_word[status_out_pkg::ST_ENABLED] = state_q.enabled;
			read_word[status_out_pkg::ST_CHARGED] = state_q.charge_done;
			read_word[status_out_pkg::ST_UNDERVOLT] = undervolt_now;
			read_word[status_out_pkg::ST_NEXTINPOS] = state_q.nextinpos;
		end
		if (haddr[31:8] != 24'h00_0000) begin
			read_word = 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state.
	always_comb begin
		state_d = state_q;
		state_d.level = level_now;
		state_d.vel_low = vel_low_now;
		state_d.vel_high = vel_high_now;
		state_d.enabled = enabled_now;
		// Division by a constant costs area but keeps the band exact to one percent.
		state_d.band = state_q.max_speed / status_out_pkg::BAND_DIVISOR;
		if (link_charged) begin
			state_d.charge_done = 1'b1;
		end
		// The first block wins over any other event in the same cycle.
		if (first_block_start) begin
			state_d.nextinpos = 1'b0;
		end else begin
			case (state_q.style)
				status_out_pkg::STYLE_TOGGLE_START: begin
					if (block_start) begin
						state_d.nextinpos = !state_q.nextinpos;
					end
				end
				status_out_pkg::STYLE_PULSE: begin
					if (block_end) begin
						state_d.nextinpos = 1'b1;
					end else if (block_start) begin
						state_d.nextinpos = 1'b0;
					end
				end
				status_out_pkg::STYLE_TOGGLE_END: begin
					if (block_end) begin
						state_d.nextinpos = !state_q.nextinpos;
					end
				end
				default: state_d.nextinpos = state_q.nextinpos;
			endcase
		end
		// Data phase of a write: the address was captured one cycle earlier.
		if (state_q.wr_pend) begin
			if (state_q.wr_addr == status_out_pkg::OFS_FUNC_SEL_1) begin
				state_d.func_sel[0] = hwdata[5:0];
			end else if (state_q.wr_addr == status_out_pkg::OFS_AUX_1) begin
				state_d.aux[0] = hwdata;
			end else if (state_q.wr_addr == status_out_pkg::OFS_FUNC_SEL_2) begin
				state_d.func_sel[1] = hwdata[5:0];
			end else if (state_q.wr_addr == status_out_pkg::OFS_AUX_2) begin
				state_d.aux[1] = hwdata;
			end else if (state_q.wr_addr == status_out_pkg::OFS_MAX_SPEED) begin
				state_d.max_speed = hwdata;
			end else if (state_q.wr_addr == status_out_pkg::OFS_UNDERVOLT) begin
				state_d.undervolt = hwdata[15:0];
			end else if (state_q.wr_addr == status_out_pkg::OFS_CTRL) begin
				state_d.sw_enable = hwdata[status_out_pkg::CTRL_SW_ENABLE];
				state_d.style = hwdata[status_out_pkg::CTRL_STYLE_LO +: 2];
				state_d.io_exp = hwdata[status_out_pkg::CTRL_IO_EXP];
			end
		end
		state_d.wr_pend = addr_phase && hwrite;
		state_d.wr_addr = (addr_phase && haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFF;
		if (addr_phase && !hwrite) begin
			state_d.rdata = read_word;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q.func_sel <= {2{status_out_pkg::RST_FUNC_SEL}};
			state_q.aux <= {2{status_out_pkg::RST_AUX}};
			state_q.max_speed <= status_out_pkg::RST_MAX_SPEED;
			state_q.undervolt <= status_out_pkg::RST_UNDERVOLT;
			state_q.sw_enable <= 1'b0;
			state_q.style <= status_out_pkg::STYLE_TOGGLE_START;
			state_q.io_exp <= 1'b0;
			state_q.band <= 32'h0000_0000;
			state_q.charge_done <= 1'b0;
			state_q.nextinpos <= 1'b0;
			state_q.level <= 2'b00;
			state_q.vel_low <= 2'b00;
			state_q.vel_high <= 2'b00;
			state_q.enabled <= 1'b0;
			state_q.wr_pend <= 1'b0;
			state_q.wr_addr <= 8'hFF;
			state_q.rdata <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs. Code changes are meant to happen with the drive disabled, so no glitch guard.
	assign logic_status_output = state_q.level;
	assign drive_enabled = state_q.enabled;
	assign hrdata = state_q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
endmodule // status_outputs

// [tb/status_outputs_sva.sv]
// Purpose: Port checker for the configurable status outputs.
// Assumes: Function codes and the first aux value are shadowed from bus writes.
// Notes: Shadows follow the zero-wait write walk, so they change with the slave.
`timescale 1ns/10ps
module status_outputs_sva (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	// Drive state
	input wire logic hw_enable_pin,
	input wire logic signed [15:0] analog_input_one_mv,
	input wire logic following_error_exceeded,
	input wire logic [5:0] position_register,
	input wire logic error_present,
	input wire logic warning_present,
	input wire logic disabling_error,
	input wire logic first_block_start,
	// Outputs
	input wire logic [1:0] logic_status_output,
	input wire logic drive_enabled
);
	logic wr_q;
	logic [7:0] wa_q;
	logic [5:0] fn0_q;
	logic [5:0] fn1_q;
	logic [31:0] aux0_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
			fn0_q <= status_out_pkg::RST_FUNC_SEL;
			fn1_q <= status_out_pkg::RST_FUNC_SEL;
			aux0_q <= status_out_pkg::RST_AUX;
		end else begin
			wr_q <= hsel && htrans[1] && hready && hwrite;
			wa_q <= haddr[7:0];
			if (wr_q && wa_q == status_out_pkg::OFS_FUNC_SEL_1) fn0_q <= hwdata[5:0];
			if (wr_q && wa_q == status_out_pkg::OFS_FUNC_SEL_2) fn1_q <= hwdata[5:0];
			if (wr_q && wa_q == status_out_pkg::OFS_AUX_1) aux0_q <= hwdata;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// The pin passes a two-stage synchroniser and the enable register, so three low samples suffice; four are taken.
	sequence hw_off_s;
		(!hw_enable_pin) [*4];
	endsequence
	sequence first_s;
		fn1_q == status_out_pkg::FN_NEXT_INPOS && first_block_start
			##1 fn1_q == status_out_pkg::FN_NEXT_INPOS;
	endsequence
	err_warn_a: assert property (fn0_q == status_out_pkg::FN_ERR_WARN |=>
		logic_status_output[0] == $past(error_present || warning_present)) else $error("Bad fault out");
	err_only_a: assert property (fn1_q == status_out_pkg::FN_ERR |=>
		logic_status_output[1] == $past(error_present)) else $error("Bad error out");
	follow_err_a: assert property (fn0_q == status_out_pkg::FN_FOLLOW_ERR |=>
		logic_status_output[0] == !$past(following_error_exceeded)) else $error("Bad follow out");
	posreg_mirror_a: assert property (fn0_q inside {[6'h0C:6'h0F]} |=>
		logic_status_output[0] == $past(position_register[fn0_q - 6'h0B])) else $error("Bad mirror");
	posreg_any_a: assert property (fn0_q == status_out_pkg::FN_POSREG_ANY |=>
		logic_status_output[0] == $past(|position_register)) else $error("Bad register OR");
	off_low_a: assert property (fn0_q inside {6'h00, 6'h17, 6'h19, 6'h1A, 6'h1B} |=>
		!logic_status_output[0]) else $error("Unused code drives high");
	ai_above_a: assert property (fn0_q == status_out_pkg::FN_AI1_ABOVE |=>
		logic_status_output[0] == $past(analog_input_one_mv > $signed(aux0_q))) else $error("Bad AI");
	next_first_a: assert property (first_s |=> !logic_status_output[1])
		else $error("First block did not clear");
	fault_off_a: assert property (disabling_error |=> !drive_enabled)
		else $error("Enabled despite fault");
	hw_off_a: assert property (hw_off_s |=> !drive_enabled)
		else $error("Enabled without pin");
endmodule // status_outputs_sva
bind status_outputs status_outputs_sva i_status_outputs_sva (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .hw_enable_pin, .analog_input_one_mv,
	.following_error_exceeded, .position_register, .error_present, .warning_present,
	.disabling_error, .first_block_start, .logic_status_output, .drive_enabled);

// [tb/status_reader.sv]
// Purpose: Far-side controller that watches the status outputs.
// Assumes: It samples on the drive clock, like a logic input would.
// Notes: A slow reader would miss short style 1 highs; this one counts every rise of the second output.
`timescale 1ns/10ps
module status_reader (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Observed outputs
	input wire logic [1:0] levels,
	output logic [7:0] rises
);
	logic prev_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_q <= 1'b0;
			rises <= 8'h00;
		end else begin
			prev_q <= levels[1];
			if (levels[1] && !prev_q) rises <= rises + 8'h01;
		end
	end
endmodule // status_reader

// [tb/tb.sv]
// Purpose: Self-checking bench for the status outputs over AHB-Lite.
// Assumes: Zero-wait slave; outputs settle within three cycles of an input.
// Notes: Checks after the settle wait are made at the falling edge; bus read checks and the first enable check follow a rising edge.
`timescale 1ns/10ps
module tb;
	logic hclk, hresetn, hsel, hwrite, hw_enable_pin, zero_mark_pin, link_charged, regen_exceeded;
	logic sw_limit_reached, target_in_window, sequence_active, last_task, following_error_exceeded;
	logic foldback_reached, error_present, warning_present, disabling_error, reference_available;
	logic first_block_start, block_start, block_end, hreadyout, hresp, drive_enabled;
	logic [31:0] haddr, hwdata, hrdata, actual_velocity, rms_current_ma, shaft_position;
	logic [15:0] dc_link_volts, analog_input_one_mv;
	logic [1:0] htrans, logic_status_output;
	logic [2:0] hsize;
	logic [5:0] position_register;
	logic [7:0] rises, r0;
	int comparisons, miscompares, cycles;
	logic [6:0] t1 [21] = '{7'h51, 7'h12, 7'h0A, 7'h4B, 7'h44, 7'h05, 7'h58, 7'h07, 7'h0C, 7'h4D,
		7'h0E, 7'h0F, 7'h1C, 7'h1D, 7'h5E, 7'h00, 7'h17, 7'h19, 7'h1A, 7'h1B, 7'h43};
	logic [6:0] t2 [8] = '{7'h52, 7'h4A, 7'h47, 7'h51, 7'h5C, 7'h5D, 7'h5E, 7'h45};
	logic [32:0] tv [7] = '{33'h1_0000_0032, 33'h1_FFFF_FF97, 33'h0_0000_006F, 33'h0_0000_0069,
		33'h1_FFFF_FF9D, 33'h1_0000_0078, 33'h0_0000_0032};
	logic [38:0] tm [7] = '{39'h46_0020_0000, 39'h49_0000_07D0, 39'h08_0000_07D0,
		39'h53_0000_012C, 39'h14_0000_012C, 39'h60_FFFF_FE0C, 39'h1F_FFFF_FE0C};
	logic [4:0] tn [11] = '{5'h00, 5'h03, 5'h02, 5'h10, 5'h15, 5'h13, 5'h14, 5'h08, 5'h0D, 5'h0A,
		5'h0D};
	status_outputs i_status_outputs (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .hw_enable_pin, .zero_mark_pin,
		.actual_velocity, .rms_current_ma, .shaft_position, .dc_link_volts, .analog_input_one_mv,
		.link_charged, .regen_exceeded, .sw_limit_reached, .target_in_window, .sequence_active,
		.last_task, .following_error_exceeded, .foldback_reached, .position_register,
		.error_present, .warning_present, .disabling_error, .reference_available,
		.first_block_start, .block_start, .block_end, .logic_status_output, .drive_enabled);
	status_reader i_status_reader (.hclk, .hresetn, .levels(logic_status_output), .rises);
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	task automatic conclude;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// The ceiling is several times the cycles the sequence below needs.
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			miscompares++;
			conclude();
		end
	end
	task automatic cw(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic ck(input string n, input logic e, input logic g);
		cw(n, {31'h0000_0000, e}, {31'h0000_0000, g});
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		{hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'b10, 24'h00_0000, a};
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		{hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0000_0000);
		cw($sformatf("read %h", a), e, hrdata);
		ck("hresp", 1'b0, hresp);
		ck("hreadyout", 1'b1, hreadyout);
	endtask
	task automatic so(input string n, input int o, input logic e);
		repeat (4) @(posedge hclk);
		@(negedge hclk);
		ck(n, e, logic_status_output[o]);
	endtask
	task automatic tc(input logic [5:0] f, input logic e);
		wr(status_out_pkg::OFS_FUNC_SEL_1, {26'h000_0000, f});
		so($sformatf("code %0d", f), 0, e);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata, hw_enable_pin, zero_mark_pin, link_charged} = '0;
		{regen_exceeded, sw_limit_reached, target_in_window, sequence_active, last_task} = '0;
		{following_error_exceeded, foldback_reached, error_present, warning_present} = '0;
		{disabling_error, reference_available, first_block_start, block_start, block_end} = '0;
		{actual_velocity, rms_current_ma, shaft_position, dc_link_volts} = '0;
		{analog_input_one_mv, position_register, comparisons, miscompares, cycles} = '0;
		hresetn = 1'b0;
		hsize = 3'b010;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rd(status_out_pkg::OFS_STATUS, 32'h0000_0000);
		rd(status_out_pkg::OFS_AUX_1, status_out_pkg::RST_AUX);
		rd(8'h40, 32'h0000_0000);
		ck("enabled", 1'b0, drive_enabled);
		@(posedge hclk);
		{warning_present, following_error_exceeded, foldback_reached, reference_available} <= 4'hF;
		{regen_exceeded, target_in_window, sequence_active, position_register} <= 9'h1_E4;
		wr(status_out_pkg::OFS_FUNC_SEL_2, 32'h0000_0012);
		foreach (t1[i]) tc(t1[i][5:0], t1[i][6]);
		ck("out2", 1'b0, logic_status_output[1]);
		rd(status_out_pkg::OFS_FUNC_SEL_1, 32'h0000_0003);
		@(posedge hclk);
		{error_present, warning_present, following_error_exceeded, last_task} <= 4'h9;
		{sw_limit_reached, position_register} <= 7'h61;
		wr(status_out_pkg::OFS_CTRL, 32'h0000_0008);
		foreach (t2[i]) tc(t2[i][5:0], t2[i][6]);
		ck("out2", 1'b1, logic_status_output[1]);
		wr(status_out_pkg::OFS_MAX_SPEED, 32'h0000_03E8);
		wr(status_out_pkg::OFS_AUX_1, 32'h0000_0064);
		wr(status_out_pkg::OFS_FUNC_SEL_1, 32'h0000_0001);
		foreach (tv[i]) begin
			if (i == 5) wr(status_out_pkg::OFS_FUNC_SEL_1, 32'h0000_0002);
			@(posedge hclk);
			actual_velocity <= tv[i][31:0];
			so("velocity", 0, tv[i][32]);
		end
		@(posedge hclk);
		{shaft_position, rms_current_ma} <= {32'h0020_0001, 32'hFFFF_F448};
		{dc_link_volts, analog_input_one_mv} <= {16'h0190, 16'hFE70};
		foreach (tm[i]) begin
			wr(status_out_pkg::OFS_AUX_1, tm[i][31:0]);
			tc(tm[i][37:32], tm[i][38]);
		end
		@(posedge hclk);
		{analog_input_one_mv, shaft_position} <= {16'hFDA8, 32'h0020_0000};
		tc(6'h1F, 1'b1);
		tc(6'h20, 1'b0);
		wr(status_out_pkg::OFS_AUX_1, 32'h0020_0000);
		tc(6'h06, 1'b0);
		wr(status_out_pkg::OFS_FUNC_SEL_1, 32'h0000_0016);
		@(posedge hclk);
		zero_mark_pin <= 1'b1;
		repeat (2) @(posedge hclk);
		zero_mark_pin <= 1'b0;
		@(posedge hclk);
		@(negedge hclk);
		ck("zero mark", 1'b1, logic_status_output[0]);
		so("zero mark end", 0, 1'b0);
		wr(status_out_pkg::OFS_FUNC_SEL_2, 32'h0000_0010);
		foreach (tn[i]) begin
			wr(status_out_pkg::OFS_CTRL, {29'h0000_0000, tn[i][4:3], 1'b0});
			@(posedge hclk);
			{first_block_start, block_end, block_start} <= {tn[i][2:1] == 2'b00, tn[i][2:1]};
			@(posedge hclk);
			{first_block_start, block_start, block_end} <= 3'b000;
			so("next inpos", 1, tn[i][0]);
			if (i == 0) r0 = rises;
		end
		cw("rises", 32'h0000_0004, {24'h00_0000, rises - r0});
		wr(status_out_pkg::OFS_FUNC_SEL_1, 32'h0000_0015);
		wr(status_out_pkg::OFS_FUNC_SEL_2, 32'h0000_0003);
		wr(status_out_pkg::OFS_UNDERVOLT, 32'h0000_00C8);
		wr(status_out_pkg::OFS_CTRL, 32'h0000_0001);
		@(posedge hclk);
		{hw_enable_pin, link_charged} <= 2'b11;
		@(posedge hclk);
		link_charged <= 1'b0;
		so("enabled out", 0, 1'b1);
		ck("charging", 1'b0, logic_status_output[1]);
		rd(status_out_pkg::OFS_STATUS, 32'h0000_002D);
		@(posedge hclk);
		dc_link_volts <= 16'h0096;
		so("undervolt", 0, 1'b0);
		ck("enabled", 1'b0, drive_enabled);
		ck("recharging", 1'b1, logic_status_output[1]);
		@(posedge hclk);
		{dc_link_volts, disabling_error} <= {16'h0190, 1'b1};
		so("fault", 0, 1'b0);
		@(posedge hclk);
		disabling_error <= 1'b0;
		so("re-enabled", 0, 1'b1);
		@(posedge hclk);
		hw_enable_pin <= 1'b0;
		so("pin off", 0, 1'b0);
		conclude();
	end
endmodule // tb
